// [sdac_backend.sv]
// digital back end of the two sigma-delta converters
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sdac_params.svh"

module sdac_backend
    import sdac_pkg::*;
#(
    parameter int MOD_DIV = 8,
    parameter int DEC_MULT = 8
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [3:0] ADDR,
    input wire logic [23:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [23:0] RDATA,
    input wire logic [1:0] MOD_BIT,
    input wire logic REF_LOW,
    input wire logic REF_OPEN_P,
    input wire logic REF_OPEN_N,
    input wire logic [23:0] NVM_DATA,
    output logic NVM_RD,
    output logic [1:0] NVM_ADDR,
    output logic [1:0] CHOP,
    output logic [1:0] CAL_ZERO,
    output logic [1:0] CAL_FULL,
    output logic BURNOUT_SRC_EN,
    output logic BURNOUT_SINK_EN,
    output logic [1:0] BURNOUT_CH,
    output logic [1:0] EXC_A_SEL,
    output logic [1:0] EXC_B_SEL
);

    sdac_state_type r, n;

    function automatic logic signed [23:0] sat24(
        input logic signed [49:0] v
    );
        if (v > 50'sh7FFFFF)
            return 24'sh7FFFFF;
        else if (v < -50'sh800000)
            return 24'sh800000;
        else
            return v[23:0];
    endfunction : sat24

    function automatic logic is_cal(input logic [2:0] m);
        return m[2];
    endfunction : is_cal

    always_comb begin
        logic tick;
        logic restart;
        logic run;
        logic [10:0] rate;
        logic [35:0] c1, c2, c3;
        logic signed [23:0] w, avg, sc;
        logic [24:0] sum;
        logic signed [24:0] diff;
        logic signed [49:0] prod;
        logic [23:0] code;
        tick = 1'b0;
        restart = 1'b0;
        run = 1'b0;
        rate = '0;
        c1 = '0;
        c2 = '0;
        c3 = '0;
        w = '0;
        avg = '0;
        sc = '0;
        sum = '0;
        diff = '0;
        prod = '0;
        code = '0;
        n = r;
        n.nvm_rd = 1'b0;
        // reference detect
        n.refm = REF_LOW | REF_OPEN_P | REF_OPEN_N; // RQ4
        tick = (r.mcnt == 8'(MOD_DIV - 1));
        n.mcnt = tick ? 8'h00 : r.mcnt + 8'h01;

        // register read, data one cycle later
        n.rdata = 24'h000000;
        if (RD) begin
            case (ADDR)
                `SDAC_A_STAT: n.rdata = {19'h0, r.refm, r.err, r.rdy};
                `SDAC_A_MODE: n.rdata = {19'h0, r.conv_en, r.mode};
                `SDAC_A_CTL0: n.rdata = {21'h0, r.chan0, r.uni[0]};
                `SDAC_A_CTL1: n.rdata = {23'h0, r.uni[1]};
                `SDAC_A_SF: n.rdata = {16'h0, r.sf};
                `SDAC_A_CURRENT_SOURCE_CONTROL: n.rdata = {19'h0, r.current_source_control};
                `SDAC_A_DAT0: n.rdata = r.data[0];
                `SDAC_A_DAT1: n.rdata = r.data[1];
                `SDAC_A_OFF0: n.rdata = r.off[0];
                `SDAC_A_OFF1: n.rdata = r.off[1];
                `SDAC_A_GAN0: n.rdata = r.gain[0];
                `SDAC_A_GAN1: n.rdata = r.gain[1];
                default: n.rdata = 24'h000000;
            endcase
        end

        // factory coefficient load after reset
        case (r.st)
            ST_LOAD: begin
                case (r.ld_ph)
                    2'h0: begin
                        n.nvm_rd = 1'b1;
                        n.ld_ph = 2'h1;
                    end
                    2'h1: n.ld_ph = 2'h2;
                    default: begin
                        case (r.ld_idx)
                            2'h0: n.off[0] = NVM_DATA; // RQ14
                            2'h1: n.off[1] = NVM_DATA; // RQ14
                            2'h2: n.gain[0] = NVM_DATA; // RQ14
                            default: n.gain[1] = NVM_DATA; // RQ14
                        endcase
                        n.ld_ph = 2'h0;
                        n.ld_idx = r.ld_idx + 2'h1;
                        if (r.ld_idx == 2'h3)
                            n.st = ST_RUN;
                    end
                endcase
            end
            ST_RUN: n.st = ST_RUN;
            default: n.st = ST_LOAD;
        endcase

        // register write
        if (WR) begin
            case (ADDR)
                `SDAC_A_STAT: begin
                    n.rdy = r.rdy & ~WDATA[1:0];
                    n.err = r.err & ~WDATA[3:2];
                end
                `SDAC_A_MODE: begin
                    n.mode = WDATA[2:0];
                    n.conv_en = WDATA[4:3];
                    restart = 1'b1;
                end
                `SDAC_A_CTL0: begin
                    n.uni[0] = WDATA[0];
                    n.chan0 = WDATA[2:1];
                    restart = 1'b1;
                end
                `SDAC_A_CTL1: begin
                    n.uni[1] = WDATA[0];
                    restart = 1'b1;
                end
                `SDAC_A_SF: begin
                    n.sf = WDATA[7:0]; // RQ9 RQ11
                    restart = 1'b1;
                end
                `SDAC_A_CURRENT_SOURCE_CONTROL: n.current_source_control = WDATA[4:0];
                `SDAC_A_OFF0: n.off[0] = WDATA;
                `SDAC_A_OFF1: n.off[1] = WDATA;
                `SDAC_A_GAN0: n.gain[0] = WDATA;
                `SDAC_A_GAN1: n.gain[1] = WDATA;
                default: n.st = n.st;
            endcase
        end

        // per converter filter, chop average, scaling, calibration
        for (int k = 0; k < 2; k++) begin
            if (restart) begin
                n.i1[k] = '0;
                n.i2[k] = '0;
                n.i3[k] = '0;
                n.d1[k] = '0;
                n.d2[k] = '0;
                n.d3[k] = '0;
                n.dcnt[k] = '0;
                n.chop[k] = 1'b0;
                n.ocnt[k] = 1'b0; // RQ13
                n.cal_act[k] = is_cal(WDATA[2:0]) & WDATA[3 + k]
                    & (ADDR == `SDAC_A_MODE); // RQ15
                if (n.cal_act[k]) begin
                    n.err[k] = 1'b0;
                    n.cal_bad[k] = 1'b0;
                end
            end else begin
                run = (r.st == ST_RUN) & (r.cal_act[k]
                    | ((r.mode == `SDAC_MD_CONT) & r.conv_en[k]));
                // slowest rate during calibration
                rate = r.cal_act[k] ? 11'(`SDAC_SF_CAL * DEC_MULT)
                    : 11'(r.sf * DEC_MULT); // RQ19 RQ9
                if (run && tick) begin
                    // chop undone digitally on the bit stream
                    n.i1[k] = r.i1[k] + ((MOD_BIT[k] ^ r.chop[k])
                        ? 36'h000000001 : 36'hFFFFFFFFF); // RQ9
                    n.i2[k] = r.i2[k] + r.i1[k]; // RQ9
                    n.i3[k] = r.i3[k] + r.i2[k]; // RQ9
                    n.dcnt[k] = r.dcnt[k] + 11'h001;
                    if (r.dcnt[k] == rate - 11'h001) begin
                        n.dcnt[k] = '0;
                        c1 = r.i3[k] - r.d1[k];
                        c2 = c1 - r.d2[k];
                        c3 = c2 - r.d3[k];
                        n.d1[k] = r.i3[k];
                        n.d2[k] = c1;
                        n.d3[k] = c2;
                        n.chop[k] = ~r.chop[k]; // RQ24
                        w = sat24(50'($signed(c3) >>> `SDAC_WORD_SH));
                        n.prev[k] = w;
                        n.ocnt[k] = 1'b1;
                        sum = {w[23], w} + {r.prev[k][23], r.prev[k]};
                        avg = sum[24:1]; // RQ12
                        diff = {avg[23], avg}
                            - {r.off[k][23], r.off[k]}; // RQ20
                        prod = diff * $signed({1'b0, r.gain[k]}); // RQ20
                        sc = sat24(prod >>> `SDAC_GAIN_SH);
                        if (!r.uni[k])
                            code = {~sc[23], sc[22:0]}; // RQ23
                        else if (sc[23])
                            code = 24'h000000;
                        else if (sc[22])
                            code = `SDAC_ONES;
                        else
                            code = {sc[22:0], 1'b0};
                        if (r.ocnt[k] && r.cal_act[k]) begin
                            // update only with a good reference
                            if (!r.cal_bad[k] && !r.refm) begin // RQ6
                                if (r.mode[0])
                                    n.gain[k] = avg; // RQ16 RQ15
                                else
                                    n.off[k] = avg; // RQ16 RQ15
                            end
                            n.cal_act[k] = 1'b0;
                            n.rdy[k] = 1'b1; // RQ22
                        end else if (r.ocnt[k]) begin
                            n.data[k] = r.refm ? `SDAC_ONES : code; // RQ5
                            n.rdy[k] = 1'b1; // RQ13
                        end
                    end
                end
            end
            if (r.cal_act[k] && r.refm) begin
                n.cal_bad[k] = 1'b1; // RQ6
                n.err[k] = 1'b1; // RQ6
            end
        end

        // calibration over, converters back to idle
        if ((|r.cal_act) && !(|n.cal_act) && !restart)
            n.mode = `SDAC_MD_IDLE;

        if (RST) begin
            n = '0;
            n.st = ST_LOAD;
            n.sf = `SDAC_SF_RST; // RQ10
        end
    end

    always_ff @(posedge SYS_CLK) begin
        r <= n;
    end

    // register bus and factory memory
    assign RDATA = r.rdata;
    assign NVM_RD = r.nvm_rd;
    assign NVM_ADDR = r.ld_idx;
    assign CHOP = r.chop; // RQ24

    // internal calibration source select
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            CAL_ZERO[k] = r.cal_act[k] & (r.mode == `SDAC_MD_IZ); // RQ17
            CAL_FULL[k] = r.cal_act[k] & (r.mode == `SDAC_MD_IF); // RQ17
        end
    end

    // burnout and excitation current steering
    assign BURNOUT_SRC_EN = r.current_source_control[`SDAC_IC_BO]; // RQ1
    assign BURNOUT_SINK_EN = r.current_source_control[`SDAC_IC_BO]; // RQ1
    assign BURNOUT_CH = r.chan0; // RQ2

    always_comb begin
        if (r.current_source_control[`SDAC_IC_CMB]) begin
            EXC_A_SEL = r.current_source_control[`SDAC_IC_TGT] ? 2'h2 : 2'h1; // RQ3
            EXC_B_SEL = r.current_source_control[`SDAC_IC_TGT] ? 2'h2 : 2'h1; // RQ3
        end else begin
            EXC_A_SEL = {1'b0, r.current_source_control[`SDAC_IC_EA]}; // RQ3
            EXC_B_SEL = {r.current_source_control[`SDAC_IC_EB], 1'b0}; // RQ3
        end
    end

endmodule : sdac_backend
`default_nettype wire

// [sdac_backend_tb.sv]
// self-checking bench for the converter back end
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    n_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module sdac_backend_tb;
    localparam logic [95:0] FACT = 96'h3C3C3C_2A2A2A_001234_00ABCD;
    localparam logic [4:0] ICT [6] = '{5'h01, 5'h06, 5'h02, 5'h08,
        5'h18, 5'h00};
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic rl = 1'b0, rp = 1'b0, rn = 1'b0, bse, bsk, nvr;
    logic [3:0] addr = 4'h0;
    logic [23:0] wd = 24'h0, rdata, nvd, q, o, g;
    logic [1:0] nva, mb, chop, cz, cf, bch, ea, eb;
    int n_errors = 0, checks_done = 0, n;
    sdac_backend #(.MOD_DIV(1), .DEC_MULT(1)) dut (.SYS_CLK(clk),
        .RST(rst), .ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd),
        .RDATA(rdata), .MOD_BIT(mb), .REF_LOW(rl), .REF_OPEN_P(rp),
        .REF_OPEN_N(rn), .NVM_DATA(nvd), .NVM_RD(nvr), .NVM_ADDR(nva),
        .CHOP(chop), .CAL_ZERO(cz), .CAL_FULL(cf), .BURNOUT_SRC_EN(bse),
        .BURNOUT_SINK_EN(bsk), .BURNOUT_CH(bch), .EXC_A_SEL(ea),
        .EXC_B_SEL(eb));
    sdac_far_model #(.FACT(FACT)) far (.SYS_CLK(clk), .NVM_RD(nvr),
        .NVM_ADDR(nva), .CAL_ZERO(cz), .CAL_FULL(cf), .CHOP(chop),
        .NVM_DATA(nvd),
        .MOD_BIT(mb));
    task automatic wreg(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [3:0] a, output logic [23:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg
    task automatic wait_rdy(input int lim);
        n = 0;
        q = 24'h0;
        while (q[0] !== 1'b1 && n < lim) begin
            rreg(4'h0, q);
            n += 2;
        end
    endtask : wait_rdy
    task automatic t_boot;
        repeat (20) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rreg(4'h8 + i[3:0], q);
            `CHK("factory word", FACT[i*24 +: 24], q)
        end
        rreg(4'h4, q);
        `CHK("rate reset", 24'h45, q)
        rreg(4'hE, q);
        `CHK("unmapped", 24'h0, q)
    endtask : t_boot
    task automatic t_current_source_control;
        logic [4:0] v;
        logic [1:0] sa, sb;
        for (int i = 0; i < 6; i++) begin
            v = ICT[i];
            sa = v[3] ? (v[4] ? 2'h2 : 2'h1) : {1'b0, v[1]};
            sb = v[3] ? (v[4] ? 2'h2 : 2'h1) : {v[2], 1'b0};
            wreg(4'h5, {19'h0, v});
            #1;
            `CHK("burnout", {v[0], v[0]}, {bse, bsk})
            `CHK("exc a", sa, ea)
            `CHK("exc b", sb, eb)
        end
        wreg(4'h2, 24'h6);
        #1;
        `CHK("burnout chan", 2'h3, bch)
    endtask : t_current_source_control
    task automatic t_conv;
        int sf;
        logic c0;
        for (int k = 0; k < 2; k++) begin
            sf = k ? 255 : 13;
            wreg(4'h4, sf[23:0]);
            wreg(4'h1, 24'h09);
            wreg(4'h0, 24'hF);
            wait_rdy(4 * sf);
            `CHK("first", 1'b1, n >= 2*sf-8 && n <= 2*sf+6)
            wreg(4'h0, 24'h1);
            #1 c0 = chop[0];
            wait_rdy(4 * sf);
            `CHK("period", 1'b1, n >= sf-10 && n <= sf+6)
            `CHK("chop", ~c0, chop[0])
        end
    endtask : t_conv
    task automatic t_ref;
        wreg(4'h4, 24'd13);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            {rl, rp, rn} <= 3'b001 << i;
            repeat (40) @(posedge clk);
            rreg(4'h6, q);
            `CHK("data on loss", 24'hFFFFFF, q)
            rreg(4'h0, q);
            `CHK("ref flag", 1'b1, q[4])
            @(posedge clk);
            {rl, rp, rn} <= 3'b000;
            repeat (4) @(posedge clk);
            rreg(4'h0, q);
            `CHK("ref flag off", 1'b0, q[4])
        end
    endtask : t_ref
    task automatic t_cal;
        for (int m = 4; m < 8; m++) begin
            rreg(4'h8, o);
            rreg(4'hA, g);
            wreg(4'h1, {19'h0, 2'b01, m[2:0]});
            wreg(4'h0, 24'hF);
            #1;
            `CHK("zero source", m == 4, cz[0])
            `CHK("full source", m == 5, cf[0])
            wait_rdy(800);
            `CHK("slow rate", 1'b1, n >= 400 && n < 800)
            rreg(4'h0, q);
            `CHK("cal error", 1'b0, q[2])
            rreg(4'h1, q);
            `CHK("mode back", 24'h08, q)
            rreg(4'h9, q);
            `CHK("aux kept", FACT[47:24], q)
            rreg(4'h8, q);
            `CHK("offset", m[0], q === o)
            rreg(4'hA, q);
            `CHK("gain", ~m[0], q === g)
        end
        rreg(4'hA, g);
        wreg(4'h1, 24'h0D);
        repeat (100) @(posedge clk);
        rp <= 1'b1;
        repeat (600) @(posedge clk);
        rp <= 1'b0;
        rreg(4'h0, q);
        `CHK("cal error", 1'b1, q[2])
        rreg(4'hA, q);
        `CHK("gain kept", g, q)
    endtask : t_cal
    task automatic t_code;
        wreg(4'h4, 24'd13);
        wreg(4'h8, 24'h800000);
        wreg(4'hA, 24'h7FFFFF);
        wreg(4'h9, 24'h7FFFFF);
        wreg(4'hB, 24'h7FFFFF);
        wreg(4'h1, 24'h19);
        repeat (60) @(posedge clk);
        rreg(4'h6, q);
        `CHK("positive full", 24'hFFFFFF, q)
        rreg(4'h7, q);
        `CHK("negative full", 24'h000000, q)
        wreg(4'hA, 24'h000000);
        repeat (40) @(posedge clk);
        rreg(4'h6, q);
        `CHK("bipolar zero", 24'h800000, q)
        wreg(4'h2, 24'h1);
        repeat (60) @(posedge clk);
        rreg(4'h6, q);
        `CHK("unipolar zero", 24'h000000, q)
    endtask : t_code
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    initial forever #5 clk = ~clk;
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_boot();
        t_current_source_control();
        t_conv();
        t_ref();
        t_cal();
        t_code();
        give_verdict();
    end
endmodule : sdac_backend_tb
`default_nettype wire

// [sdac_far_model.sv]
// factory memory and modulator stream facing the back end
`timescale 1ns/1ps
`default_nettype none
module sdac_far_model #(
    parameter logic [95:0] FACT = 96'h0
) (
    input wire logic SYS_CLK,
    input wire logic NVM_RD,
    input wire logic [1:0] NVM_ADDR,
    input wire logic [1:0] CAL_ZERO,
    input wire logic [1:0] CAL_FULL,
    input wire logic [1:0] CHOP,
    output logic [23:0] NVM_DATA,
    output logic [1:0] MOD_BIT
);
    logic [23:0] d_r = 24'h0;
    logic hold_r = 1'b0;
    logic [1:0] cnt_r = 2'h0;
    assign NVM_DATA = d_r;
    // word stands two cycles, then the bus shows garbage
    always_ff @(posedge SYS_CLK) begin
        hold_r <= NVM_RD;
        cnt_r <= cnt_r + 2'h1;
        if (NVM_RD)
            d_r <= FACT[NVM_ADDR*24 +: 24];
        else if (!hold_r)
            d_r <= ~d_r;
    end
    // pin level present before any calibration, reversed by chop
    assign MOD_BIT[0] = CHOP[0] ^ (CAL_FULL[0]
        | (CAL_ZERO[0] ? cnt_r[0] : |cnt_r));
    assign MOD_BIT[1] = CHOP[1] ^ cnt_r[0];
endmodule : sdac_far_model
`default_nettype wire

// [sdac_monitor.sv]
// port checker for the converter back end
`timescale 1ns/1ps
`default_nettype none
module sdac_monitor (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [3:0] ADDR,
    input wire logic [23:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [23:0] RDATA,
    input wire logic REF_LOW,
    input wire logic REF_OPEN_P,
    input wire logic REF_OPEN_N,
    input wire logic NVM_RD,
    input wire logic [1:0] NVM_ADDR,
    input wire logic BURNOUT_SRC_EN,
    input wire logic BURNOUT_SINK_EN,
    input wire logic [1:0] BURNOUT_CH,
    input wire logic [1:0] EXC_A_SEL,
    input wire logic [1:0] EXC_B_SEL
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    wire logic bad = REF_LOW | REF_OPEN_P | REF_OPEN_N;
    wire logic icw = WR && ADDR == 4'h5;
    logic [4:0] ic_r;
    wire logic [1:0] both = ic_r[4] ? 2'h2 : 2'h1;
    always_ff @(posedge SYS_CLK)
        if (icw) ic_r <= WDATA[4:0];
    a_burnout_pair: assert property (BURNOUT_SRC_EN == BURNOUT_SINK_EN)
        else $error("burnout pair split");
    a_burnout_bit: assert property (
        icw |=> BURNOUT_SRC_EN == $past(WDATA[0]))
        else $error("burnout enable wrong");
    a_burnout_chan: assert property (
        WR && ADDR == 4'h2 |=> BURNOUT_CH == $past(WDATA[2:1]))
        else $error("burnout channel wrong");
    a_exc_select: assert property (
        icw |=> EXC_A_SEL == (ic_r[3] ? both : {1'b0, ic_r[1]})
        && EXC_B_SEL == (ic_r[3] ? both : {ic_r[2], 1'b0}))
        else $error("excitation select wrong");
    a_load_start: assert property (
        $fell(RST) |-> ##[0:3] (NVM_RD && NVM_ADDR == 2'h0))
        else $error("factory load missing");
    a_load_step: assert property (
        NVM_RD && NVM_ADDR != 2'h3 |=> !NVM_RD ##1 !NVM_RD
        ##1 (NVM_RD && NVM_ADDR == $past(NVM_ADDR, 3) + 2'h1))
        else $error("factory load order wrong");
    a_ref_set: assert property (
        bad [*2] ##0 (RD && ADDR == 4'h0) |=> RDATA[4])
        else $error("reference flag not set");
    a_ref_clear: assert property (
        !bad [*2] ##0 (RD && ADDR == 4'h0) |=> !RDATA[4])
        else $error("reference flag stuck");
    a_read_idle: assert property (!RD |=> RDATA == 24'h0)
        else $error("read data outside read slot");
endmodule : sdac_monitor
bind sdac_backend sdac_monitor mon (.*);
`default_nettype wire

// [sdac_params.svh]
// constants for the converter back end: offsets, fields, resets, timing
// Functional notes
// RQ1 - burnout source and sink switch together
// RQ2 - burnout currents follow primary channel select
// RQ3 - excitation sources per pin, or both combined
// RQ4 - reference missing flag on low or open
// RQ5 - results all ones while reference missing
// RQ6 - reference loss blocks cal update, sets error
// RQ7 - software checks flag only on all ones
// RQ8 - software reads cal error after calibration
// RQ9 - sinc3 decimation set by decimation factor
// RQ10 - decimation factor resets to 69 decimal
// RQ11 - decimation factor usable from 13 to 255
// RQ12 - average each filter output with previous
// RQ13 - first result after two output periods
// RQ14 - factory coefficients loaded at power on
// RQ15 - calibration overwrites enabled converter coefficients
// RQ16 - zero-scale to offset, full-scale to gain
// RQ17 - internal cal selects own source, system external
// RQ18 - system cal voltage applied before start
// RQ19 - calibration always at slowest rate
// RQ20 - subtract offset before gain multiply
// RQ21 - software runs zero-scale before full-scale
// RQ22 - ready flag marks end of calibration
// RQ23 - bipolar results in offset binary
// RQ24 - chop reverses polarity each filter output
`ifndef SDAC_PARAMS_SVH
`define SDAC_PARAMS_SVH
`define SDAC_A_STAT 4'h0
`define SDAC_A_MODE 4'h1
`define SDAC_A_CTL0 4'h2
`define SDAC_A_CTL1 4'h3
`define SDAC_A_SF 4'h4
`define SDAC_A_CURRENT_SOURCE_CONTROL 4'h5
`define SDAC_A_DAT0 4'h6
`define SDAC_A_DAT1 4'h7
`define SDAC_A_OFF0 4'h8
`define SDAC_A_OFF1 4'h9
`define SDAC_A_GAN0 4'hA
`define SDAC_A_GAN1 4'hB
`define SDAC_MD_IDLE 3'h0
`define SDAC_MD_CONT 3'h1
`define SDAC_MD_IZ 3'h4
`define SDAC_MD_IF 3'h5
`define SDAC_MD_SZ 3'h6
`define SDAC_MD_SFS 3'h7
`define SDAC_SF_RST 8'h45
`define SDAC_SF_CAL 8'hFF
`define SDAC_ONES 24'hFFFFFF
`define SDAC_GAIN_SH 22
`define SDAC_WORD_SH 10
`define SDAC_IC_BO 0
`define SDAC_IC_EA 1
`define SDAC_IC_EB 2
`define SDAC_IC_CMB 3
`define SDAC_IC_TGT 4
`endif

// [sdac_pkg.sv]
// types for the converter back end
package sdac_pkg;
    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } sdac_st_type;

    typedef struct packed {
        sdac_st_type st;
        logic [1:0] ld_idx;
        logic [1:0] ld_ph;
        logic nvm_rd;
        logic [23:0] rdata;
        logic [2:0] mode;
        logic [1:0] conv_en;
        logic [1:0] uni;
        logic [1:0] chan0;
        logic [7:0] sf;
        logic [4:0] current_source_control;
        logic refm;
        logic [7:0] mcnt;
        logic [1:0][35:0] i1, i2, i3, d1, d2, d3;
        logic [1:0][10:0] dcnt;
        logic [1:0] chop, ocnt;
        logic [1:0][23:0] prev, data, off, gain;
        logic [1:0] rdy, err, cal_act, cal_bad;
    } sdac_state_type;
endpackage : sdac_pkg
